// *** design/csm_pkg.sv ***
// shared constants and types of the clock switch and fail-safe monitor
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - after a new request, keep running the old source until the new is ready
// - divider-only change or already running source is ready at once
// - new source ready sets ready bit and switch flag; interrupt if enabled
// - switch flag never wakes the device from sleep
// - hold clear: hand over as soon as the new source is ready
// - hold set: stay on old clock until hold clears or request cancels
// - current fields show old setting until handover; ready bit cleared then
// - sleep entered before handover cancels the handover
// - wake with hold clear and request pending: new clock, switch flag set
// - wake with hold set: old clock, request issued again
// - switch flag stays set until software clears it
// - request differing from current reads switch ready low, starts switch
// - monitor only when enabled; watches every external source mode
// - sample clock is the low-frequency oscillator divided by 64
// - latch set on external falling edge, cleared by sample rising edge
// - on failure force current source to 3'b110, keep divider settings
// - failure sets fail flag, interrupt if enabled; stay internal
// - fail condition cleared by reset, sleep entry or request write
// - switch back to external restarts start-up timer; fail flags again
// - monitoring starts after start-up timer; direct modes start at once
// - start-up timer counts 1024 external oscillator cycles
// - request writes ignored while switch configuration enable is clear
//////////////////////////////////////////////////////////////////////////////
package csm_pkg;

  // register indices
  localparam logic [3:0] CSM_OFF_REQUEST = 4'h0;
  localparam logic [3:0] CSM_OFF_CURRENT = 4'h1;
  localparam logic [3:0] CSM_OFF_CONTROL = 4'h2;
  localparam logic [3:0] CSM_OFF_STATUS = 4'h3;
  localparam logic [3:0] CSM_OFF_TUNE = 4'h4;
  localparam logic [3:0] CSM_OFF_FREQ = 4'h5;
  localparam logic [3:0] CSM_OFF_OSC_EN = 4'h6;
  localparam logic [3:0] CSM_OFF_IRQ_EN = 4'h7;
  localparam logic [3:0] CSM_OFF_IRQ_FLAG = 4'h8;
  localparam logic [3:0] CSM_OFF_IRQ_PRIO = 4'h9;

  // field positions
  localparam int CSM_SRC_LSB = 4;
  localparam int CSM_DIV_LSB = 0;
  localparam int CSM_HOLD_BIT = 7;
  localparam int CSM_SWITCH_READY_BIT = 4;
  localparam int CSM_NRDY_BIT = 3;
  localparam int CSM_OSCF_BIT = 7;
  localparam int CSM_CSW_BIT = 6;

  // source codes
  localparam logic [2:0] CSM_SRC_EXT_PLL = 3'h2;
  localparam logic [2:0] CSM_SRC_SOSC = 3'h4;
  localparam logic [2:0] CSM_SRC_HFINT = 3'h6;
  localparam logic [2:0] CSM_SRC_EXT = 3'h7;

  // reset values
  localparam logic [2:0] CSM_RST_SRC = 3'h6;
  localparam logic [3:0] CSM_RST_DIV = 4'h0;
  localparam logic [7:0] CSM_RST_BYTE = 8'h00;

  // timing counts
  localparam int CSM_OST_CYCLES = 1024;
  localparam int CSM_SAMPLE_DIV = 64;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } csm_bus_t;

  typedef struct packed {
    logic [2:0] src;
    logic [3:0] div;
  } csm_sel_t;

  typedef enum logic [4:0] {
    CSM_IDLE = 5'b00001,
    CSM_WAIT = 5'b00010,
    CSM_HOLD = 5'b00100,
    CSM_SWAP = 5'b01000,
    CSM_SLEEP = 5'b10000
  } csm_state_t;

endpackage

// *** design/csm_clock_switch.sv ***
// clock switch controller with fail-safe external clock monitor
//
// Design decisions made here: the address map and the plain strobed port.
module csm_clock_switch
  import csm_pkg::*;
#(
  parameter int OST_CYCLES = CSM_OST_CYCLES,
  parameter int SAMPLE_DIV = CSM_SAMPLE_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire csm_bus_t bus,
  output logic [7:0] rdata,
  // configuration straps
  input wire logic switch_cfg_enable,
  input wire logic fail_monitor_cfg_enable,
  input wire logic direct_external_clock_mode,
  // oscillator sources
  input wire logic [7:0] src_stable,
  input wire logic ext_clk_level,
  input wire logic low_freq_internal_osc,
  // power management
  input wire logic sleep_enter,
  input wire logic wake,
  // clock steering
  output csm_sel_t sys_sel,
  output logic sys_clk_gate,
  output logic in_sleep,
  // interrupts
  output logic switch_irq,
  output logic osc_fail_irq
);

  localparam int SD_W = $clog2(SAMPLE_DIV);
  localparam int OST_W = $clog2(OST_CYCLES + 1);

  csm_state_t state_reg;
  csm_sel_t req_reg;
  csm_sel_t cur_reg;
  logic hold_reg;
  logic new_ready_reg;
  logic sw_flag_reg;
  logic osc_flag_reg;
  logic sw_ie_reg;
  logic osc_ie_reg;
  logic [7:0] tune_reg;
  logic [7:0] freq_reg;
  logic [7:0] osc_en_reg;
  logic [7:0] prio_reg;
  logic fail_cond_reg;
  logic ext_prev_reg;
  logic lf_prev_reg;
  logic [SD_W-1:0] sample_cnt_reg;
  logic det_latch_reg;
  logic [OST_W-1:0] ost_cnt_reg;
  logic armed_reg;

  logic req_wr;
  logic ext_fall;
  logic lf_rise;
  logic sample_rise;
  logic sample_fall;
  logic ost_done;
  logic ost_restart;
  logic target_ready;
  logic cur_is_ext;
  logic req_is_ext;
  logic req_uses_ost;
  logic mismatch;
  logic fail_detect;
  logic cancel_fail;

  //////////////////////////////////////////////////////////////////////////////
  // decode and source classification

  assign req_wr = bus.wr && bus.addr == CSM_OFF_REQUEST
                  && switch_cfg_enable;
  assign mismatch = req_reg != cur_reg;
  assign cur_is_ext = cur_reg.src == CSM_SRC_EXT
                      || cur_reg.src == CSM_SRC_EXT_PLL
                      || cur_reg.src == CSM_SRC_SOSC;
  assign req_is_ext = req_reg.src == CSM_SRC_EXT
                      || req_reg.src == CSM_SRC_EXT_PLL;
  assign req_uses_ost = req_is_ext && !direct_external_clock_mode;
  assign ost_done = ost_cnt_reg == OST_W'(OST_CYCLES);

  // divider-only change or running source needs no start-up
  always_comb begin
    if (req_reg.src == cur_reg.src) begin
      target_ready = 1'b1;
    end else if (req_uses_ost) begin
      target_ready = ost_done && src_stable[req_reg.src];
    end else begin
      target_ready = src_stable[req_reg.src];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // start-up timer: counts external oscillator cycles

  assign ext_fall = ext_prev_reg && !ext_clk_level;
  assign ost_restart = (req_wr
                        && bus.wdata[CSM_SRC_LSB +: 3] != cur_reg.src)
                       || wake;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_clk_level;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ost_cnt_reg <= '0;
    end else if (ost_restart) begin
      ost_cnt_reg <= '0;
    end else if (ext_fall && !ost_done) begin
      ost_cnt_reg <= ost_cnt_reg + OST_W'(1);
    end
  end

  // monitor armed once start-up timer expires, at once in direct modes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b0;
    end else if (wake || state_reg == CSM_SLEEP) begin
      armed_reg <= 1'b0;
    end else if (ost_done || direct_external_clock_mode) begin
      armed_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fail-safe sample clock and detector latch

  assign lf_rise = !lf_prev_reg && low_freq_internal_osc;
  assign sample_rise = lf_rise && sample_cnt_reg == '1;
  assign sample_fall = lf_rise
                       && sample_cnt_reg == SD_W'(SAMPLE_DIV / 2 - 1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lf_prev_reg <= 1'b0;
      sample_cnt_reg <= '0;
    end else begin
      lf_prev_reg <= low_freq_internal_osc;
      if (lf_rise) begin
        sample_cnt_reg <= sample_cnt_reg + SD_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      det_latch_reg <= 1'b0;
    end else if (ext_fall) begin
      det_latch_reg <= 1'b1;
    end else if (sample_rise) begin
      det_latch_reg <= 1'b0;
    end
  end

  // whole sample half-cycle passed without an external falling edge
  assign fail_detect = fail_monitor_cfg_enable && armed_reg && cur_is_ext
                       && sample_fall && !det_latch_reg && !ext_fall
                       && !fail_cond_reg
                       && state_reg != CSM_SLEEP;
  // a completed switch back to external rearms the monitor
  assign cancel_fail = req_wr || sleep_enter
                       || state_reg == CSM_SWAP;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fail_cond_reg <= 1'b0;
    end else if (fail_detect) begin
      fail_cond_reg <= 1'b1;
    end else if (cancel_fail) begin
      fail_cond_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // switch sequencer

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= CSM_IDLE;
    end else begin
      case (state_reg)
        CSM_IDLE: begin
          if (sleep_enter) begin
            state_reg <= CSM_SLEEP;
          end else if (mismatch) begin
            state_reg <= CSM_WAIT;
          end
        end
        CSM_WAIT: begin
          if (sleep_enter) begin
            state_reg <= CSM_SLEEP;
          end else if (!mismatch) begin
            state_reg <= CSM_IDLE;
          end else if (target_ready) begin
            state_reg <= hold_reg ? CSM_HOLD : CSM_SWAP;
          end
        end
        CSM_HOLD: begin
          if (sleep_enter) begin
            state_reg <= CSM_SLEEP;
          end else if (!mismatch) begin
            state_reg <= CSM_IDLE;
          end else if (req_wr) begin
            state_reg <= CSM_WAIT;
          end else if (!hold_reg) begin
            state_reg <= CSM_SWAP;
          end
        end
        CSM_SWAP: begin
          state_reg <= CSM_IDLE;
        end
        CSM_SLEEP: begin
          if (wake) begin
            state_reg <= (mismatch && hold_reg) ? CSM_WAIT
                                                : CSM_IDLE;
          end
        end
        default: begin
          state_reg <= CSM_IDLE;
        end
      endcase
    end
  end

  // current selection changes only at handover or failure
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_reg <= '{src: CSM_RST_SRC, div: CSM_RST_DIV};
    end else if (fail_detect) begin
      cur_reg.src <= CSM_SRC_HFINT;
    end else if (state_reg == CSM_SWAP) begin
      cur_reg <= req_reg;
    end else if (state_reg == CSM_SLEEP && wake && mismatch
                 && !hold_reg) begin
      cur_reg <= req_reg;
    end
  end

  // gate low through the swap cycle so the mux moves while quiet
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_sel <= '{src: CSM_RST_SRC, div: CSM_RST_DIV};
      sys_clk_gate <= 1'b1;
      in_sleep <= 1'b0;
    end else begin
      sys_sel <= cur_reg;
      sys_clk_gate <= !((state_reg == CSM_WAIT && target_ready && !hold_reg
                         && mismatch && !sleep_enter)
                        || (state_reg == CSM_HOLD && !hold_reg && mismatch
                            && !req_wr && !sleep_enter)
                        || state_reg == CSM_SWAP);
      in_sleep <= state_reg == CSM_SLEEP ? !wake : sleep_enter;
    end
  end

  // new-source-ready bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      new_ready_reg <= 1'b0;
    end else if (state_reg == CSM_WAIT && target_ready && mismatch
                 && !sleep_enter) begin
      new_ready_reg <= 1'b1;
    end else if (state_reg == CSM_SWAP || !mismatch
                 || state_reg == CSM_SLEEP) begin
      new_ready_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_reg <= '{src: CSM_RST_SRC, div: CSM_RST_DIV};
    end else if (fail_detect && !req_wr) begin
      req_reg.src <= CSM_SRC_HFINT;
    end else if (req_wr) begin
      req_reg.src <= bus.wdata[CSM_SRC_LSB +: 3];
      req_reg.div <= bus.wdata[CSM_DIV_LSB +: 4];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_reg <= 1'b0;
      tune_reg <= CSM_RST_BYTE;
      freq_reg <= CSM_RST_BYTE;
      osc_en_reg <= CSM_RST_BYTE;
      prio_reg <= CSM_RST_BYTE;
      sw_ie_reg <= 1'b0;
      osc_ie_reg <= 1'b0;
    end else if (bus.wr) begin
      case (bus.addr)
        CSM_OFF_CONTROL: hold_reg <= bus.wdata[CSM_HOLD_BIT];
        CSM_OFF_TUNE: tune_reg <= {2'h0, bus.wdata[5:0]};
        CSM_OFF_FREQ: freq_reg <= {4'h0, bus.wdata[3:0]};
        CSM_OFF_OSC_EN: osc_en_reg <= {bus.wdata[7:2], 2'h0};
        CSM_OFF_IRQ_PRIO: prio_reg <= {bus.wdata[7:6], 6'h0};
        CSM_OFF_IRQ_EN: begin
          osc_ie_reg <= bus.wdata[CSM_OSCF_BIT];
          sw_ie_reg <= bus.wdata[CSM_CSW_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // flags: hardware set wins over a software write in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_flag_reg <= 1'b0;
      osc_flag_reg <= 1'b0;
    end else begin
      if ((state_reg == CSM_WAIT && target_ready && mismatch && !sleep_enter)
          || (state_reg == CSM_SLEEP && wake && mismatch && !hold_reg)) begin
        sw_flag_reg <= 1'b1;
      end else if (bus.wr && bus.addr == CSM_OFF_IRQ_FLAG) begin
        sw_flag_reg <= bus.wdata[CSM_CSW_BIT];
      end
      if (fail_detect) begin
        osc_flag_reg <= 1'b1;
      end else if (bus.wr && bus.addr == CSM_OFF_IRQ_FLAG) begin
        osc_flag_reg <= bus.wdata[CSM_OSCF_BIT];
      end
    end
  end

  // switch interrupt held back while asleep so it cannot wake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      switch_irq <= 1'b0;
      osc_fail_irq <= 1'b0;
    end else begin
      switch_irq <= sw_flag_reg && sw_ie_reg
                    && state_reg != CSM_SLEEP;
      osc_fail_irq <= osc_flag_reg && osc_ie_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= CSM_RST_BYTE;
    end else if (bus.rd) begin
      case (bus.addr)
        CSM_OFF_REQUEST: rdata <= {1'b0, req_reg.src, req_reg.div};
        CSM_OFF_CURRENT: rdata <= {1'b0, cur_reg.src, cur_reg.div};
        CSM_OFF_CONTROL: rdata <= {hold_reg, 2'h0, !mismatch,
                                   new_ready_reg, 3'h0};
        CSM_OFF_STATUS: rdata <= {src_stable[CSM_SRC_EXT],
                                  src_stable[CSM_SRC_HFINT], 2'h0,
                                  src_stable[CSM_SRC_SOSC], 2'h0,
                                  src_stable[CSM_SRC_EXT_PLL]};
        CSM_OFF_TUNE: rdata <= tune_reg;
        CSM_OFF_FREQ: rdata <= freq_reg;
        CSM_OFF_OSC_EN: rdata <= osc_en_reg;
        CSM_OFF_IRQ_EN: rdata <= {osc_ie_reg, sw_ie_reg, 6'h0};
        CSM_OFF_IRQ_FLAG: rdata <= {osc_flag_reg, sw_flag_reg, 6'h0};
        CSM_OFF_IRQ_PRIO: rdata <= prio_reg;
        default: rdata <= CSM_RST_BYTE;
      endcase
    end else begin
      rdata <= CSM_RST_BYTE;
    end
  end

endmodule

// *** verification/csm_clock_switch_asserts.sv ***
// port assertions for the clock switch and fail-safe monitor
module csm_clock_switch_asserts
  import csm_pkg::*;
#(
  parameter int SAMPLE_DIV = CSM_SAMPLE_DIV
) (
  // clock, reset and register port
  input wire logic clk,
  input wire logic rst,
  input wire csm_bus_t bus,
  input wire logic [7:0] rdata,
  // straps, sources and power
  input wire logic fail_monitor_cfg_enable,
  input wire logic ext_clk_level,
  input wire logic low_freq_internal_osc,
  input wire logic sleep_enter,
  input wire logic wake,
  // outputs
  input wire csm_sel_t sys_sel,
  input wire logic sys_clk_gate,
  input wire logic in_sleep,
  input wire logic switch_irq,
  input wire logic osc_fail_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ext_d, lo_d, wr_d1, wr_d2;
  int lo_cnt;
  logic quiet;

  ////////////////////////////////////////////////////////////////////////////
  // low-frequency oscillator rising edges since the last external falling edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {ext_d, lo_d, wr_d1, wr_d2} <= 4'h0;
      lo_cnt <= 0;
    end else begin
      {ext_d, lo_d, wr_d1, wr_d2} <=
        {ext_clk_level, low_freq_internal_osc, bus.wr, wr_d1};
      if (ext_d && !ext_clk_level) begin
        lo_cnt <= 0;
      end else if (!lo_d && low_freq_internal_osc) begin
        lo_cnt <= lo_cnt + 1;
      end
    end
  end
  // no write near enough to move a flag or enable
  assign quiet = !bus.wr && !wr_d1 && !wr_d2;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_gate_drop;
    $fell(sys_clk_gate);
  endsequence
  sequence s_gate_back;
    ##[1:2] sys_clk_gate;
  endsequence
  sequence s_fail_seen;
    $rose(osc_fail_irq) && quiet;
  endsequence

  a_gate_short: assert property (s_gate_drop |-> s_gate_back)
    else $error("system clock held off too long");
  a_sleep_quiet: assert property (
    in_sleep && $past(in_sleep) |-> !switch_irq)
    else $error("switch interrupt raised while asleep");
  a_sleep_enter: assert property (
    sleep_enter && !in_sleep |-> ##[1:2] in_sleep)
    else $error("sleep request not taken");
  a_sleep_stays: assert property (
    in_sleep && !wake && !$past(wake) |=> in_sleep)
    else $error("left sleep without a wake");
  a_wake_exit: assert property (
    in_sleep && wake |-> ##[1:2] !in_sleep)
    else $error("wake did not end sleep");
  a_flag_sticky: assert property (
    switch_irq && quiet && !sleep_enter && !in_sleep |=> switch_irq)
    else $error("switch interrupt dropped by itself");
  a_fail_sticky: assert property (
    osc_fail_irq && quiet && !sleep_enter |=> osc_fail_irq)
    else $error("fail interrupt dropped by itself");
  a_fail_to_hf: assert property (
    s_fail_seen |-> ##[0:3] sys_sel.src == CSM_SRC_HFINT)
    else $error("failure did not select the internal source");
  a_fail_enabled: assert property (
    s_fail_seen |-> $past(fail_monitor_cfg_enable, 2))
    else $error("failure flagged with monitor disabled");
  a_fail_slow: assert property (
    s_fail_seen |-> lo_cnt >= SAMPLE_DIV / 2 - 1)
    else $error("failure flagged too early");
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule

bind csm_clock_switch csm_clock_switch_asserts #(.SAMPLE_DIV(SAMPLE_DIV))
  u_csm_clock_switch_asserts (
  .clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
  .fail_monitor_cfg_enable(fail_monitor_cfg_enable),
  .ext_clk_level(ext_clk_level),
  .low_freq_internal_osc(low_freq_internal_osc),
  .sleep_enter(sleep_enter), .wake(wake), .sys_sel(sys_sel),
  .sys_clk_gate(sys_clk_gate), .in_sleep(in_sleep),
  .switch_irq(switch_irq), .osc_fail_irq(osc_fail_irq)
);

// *** verification/csm_osc_model.sv ***
// model of the oscillator sources beside the clock switch
module csm_osc_model
  import csm_pkg::*;
(
  // control
  input wire logic clk,
  input wire logic ext_run,
  // source outputs
  output logic [7:0] src_stable,
  output logic ext_clk_level,
  output logic low_freq_internal_osc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ext_div = 2'h0;
  logic [2:0] lo_div = 3'h0;

  // internal sources always up, external and pll only while running
  assign src_stable = {ext_run, 3'b101, 1'b0, ext_run, 2'b00};
  always @(posedge clk) begin
    lo_div <= lo_div + 3'h1;
    if (ext_run) begin
      ext_div <= ext_div + 2'h1;
    end
  end
  // a stopped oscillator sticks high: no falling edges at all
  assign ext_clk_level = ext_run ? ext_div[1] : 1'b1;
  assign low_freq_internal_osc = lo_div[2];
endmodule

// *** verification/tb_top.sv ***
// testbench for the clock switch with fail-safe monitor
module tb_top
  import csm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  csm_bus_t bus = '0;
  logic switch_cfg_enable = 1'b1;
  logic fail_monitor_cfg_enable = 1'b1;
  logic sleep_enter = 1'b0;
  logic wake = 1'b0;
  logic ext_run = 1'b0;
  logic direct_mode = 1'b0;
  logic [7:0] rdata, src_stable;
  logic ext_clk_level, low_freq_internal_osc;
  logic sys_clk_gate, in_sleep, switch_irq, osc_fail_irq;
  csm_sel_t sys_sel;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  csm_osc_model u_csm_osc_model (
    .clk(clk), .ext_run(ext_run), .src_stable(src_stable),
    .ext_clk_level(ext_clk_level),
    .low_freq_internal_osc(low_freq_internal_osc)
  );
  csm_clock_switch #(.OST_CYCLES(16), .SAMPLE_DIV(8)) u_csm_clock_switch (
    .clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .switch_cfg_enable(switch_cfg_enable),
    .fail_monitor_cfg_enable(fail_monitor_cfg_enable),
    .direct_external_clock_mode(direct_mode), .src_stable(src_stable),
    .ext_clk_level(ext_clk_level),
    .low_freq_internal_osc(low_freq_internal_osc),
    .sleep_enter(sleep_enter), .wake(wake), .sys_sel(sys_sel),
    .sys_clk_gate(sys_clk_gate), .in_sleep(in_sleep),
    .switch_irq(switch_irq), .osc_fail_irq(osc_fail_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  // bounded wait for a selection, then compare it
  task automatic wait_sel(input logic [6:0] s, input int lim);
    for (int i = 0; i < lim && sys_sel !== s; i++)
      @(negedge clk);
    chk({1'b0, sys_sel}, {1'b0, s});
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wait_sel(7'h60, 0);
    rd_chk(CSM_OFF_REQUEST, 8'h60);
    rd_chk(CSM_OFF_CURRENT, 8'h60);
    rd_chk(CSM_OFF_CONTROL, 8'h10);
    rd_chk(4'hf, 8'h00);
    chk({7'h0, sys_clk_gate}, 8'h01);
    $display("test reset done");
  endtask
  task automatic t_div();
    wr_reg(CSM_OFF_IRQ_EN, 8'h40);
    wr_reg(CSM_OFF_REQUEST, 8'h63);
    wait_sel(7'h63, 10);
    rd_chk(CSM_OFF_CURRENT, 8'h63);
    rd_chk(CSM_OFF_CONTROL, 8'h10);
    rd_chk(CSM_OFF_IRQ_FLAG, 8'h40);
    chk({7'h0, switch_irq}, 8'h01);
    $display("test divider done");
  endtask
  task automatic t_ext();
    wr_reg(CSM_OFF_REQUEST, 8'h72);
    rd_chk(CSM_OFF_IRQ_FLAG, 8'h40);
    rd_chk(CSM_OFF_CONTROL, 8'h00);
    idle(100);
    rd_chk(CSM_OFF_CURRENT, 8'h63);
    @(posedge clk) ext_run <= 1'b1;
    idle(40);
    wait_sel(7'h63, 0);
    wait_sel(7'h72, 100);
    $display("test external done");
  endtask
  task automatic t_hold();
    wr_reg(CSM_OFF_CONTROL, 8'h80);
    wr_reg(CSM_OFF_REQUEST, 8'h62);
    idle(30);
    wait_sel(7'h72, 0);
    rd_chk(CSM_OFF_CONTROL, 8'h88);
    wr_reg(CSM_OFF_REQUEST, 8'h72);
    rd_chk(CSM_OFF_CONTROL, 8'h90);
    wr_reg(CSM_OFF_CONTROL, 8'h00);
    idle(10);
    wait_sel(7'h72, 0);
    $display("test hold done");
  endtask
  task automatic t_fail();
    wr_reg(CSM_OFF_IRQ_EN, 8'hc0);
    wr_reg(CSM_OFF_IRQ_FLAG, 8'h00);
    idle(200);
    chk({7'h0, osc_fail_irq}, 8'h00);
    @(posedge clk) ext_run <= 1'b0;
    for (int i = 0; i < 300 && osc_fail_irq !== 1'b1; i++)
      @(negedge clk);
    chk({7'h0, osc_fail_irq}, 8'h01);
    wait_sel(7'h62, 5);
    rd_chk(CSM_OFF_IRQ_FLAG, 8'h80);
    wr_reg(CSM_OFF_IRQ_FLAG, 8'h00);
    @(posedge clk) ext_run <= 1'b1;
    wr_reg(CSM_OFF_REQUEST, 8'h72);
    idle(20);
    wait_sel(7'h62, 0);
    wait_sel(7'h72, 150);
    chk({7'h0, osc_fail_irq}, 8'h00);
    $display("test fail done");
  endtask
  task automatic t_sleep();
    wr_reg(CSM_OFF_IRQ_FLAG, 8'h00);
    fail_monitor_cfg_enable <= 1'b0;
    ext_run <= 1'b0;
    idle(200);
    chk({7'h0, osc_fail_irq}, 8'h00);
    wr_reg(CSM_OFF_REQUEST, 8'h25);
    sleep_enter <= 1'b1;
    @(posedge clk) sleep_enter <= 1'b0;
    @(posedge clk) ext_run <= 1'b1;
    idle(100);
    chk({7'h0, in_sleep}, 8'h01);
    wait_sel(7'h72, 0);
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    wait_sel(7'h25, 10);
    chk({7'h0, in_sleep}, 8'h00);
    rd_chk(CSM_OFF_IRQ_FLAG, 8'h40);
    $display("test sleep done");
  endtask
  task automatic t_lock();
    @(posedge clk) switch_cfg_enable <= 1'b0;
    wr_reg(CSM_OFF_REQUEST, 8'h60);
    idle(10);
    rd_chk(CSM_OFF_REQUEST, 8'h25);
    wait_sel(7'h25, 0);
    @(posedge clk) switch_cfg_enable <= 1'b1;
    $display("test lock done");
  endtask
  task automatic t_resume();
    wr_reg(CSM_OFF_CONTROL, 8'h80);
    wr_reg(CSM_OFF_REQUEST, 8'h61);
    idle(5);
    @(posedge clk) sleep_enter <= 1'b1;
    @(posedge clk) sleep_enter <= 1'b0;
    idle(5);
    chk({7'h0, in_sleep}, 8'h01);
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    idle(5);
    wait_sel(7'h25, 0);
    chk({7'h0, in_sleep}, 8'h00);
    rd_chk(CSM_OFF_CONTROL, 8'h88);
    wr_reg(CSM_OFF_CONTROL, 8'h00);
    wait_sel(7'h61, 10);
    @(posedge clk) direct_mode <= 1'b1;
    wr_reg(CSM_OFF_REQUEST, 8'h70);
    wait_sel(7'h70, 10);
    $display("test resume done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_div();
    t_ext();
    t_hold();
    t_fail();
    t_sleep();
    t_lock();
    t_resume();
    stop_test();
  end
endmodule
